// ==== charger_params.svh ====
// Command codes, field positions, reset values and limits of the setting registers
`ifndef CHARGER_PARAMS_SVH
`define CHARGER_PARAMS_SVH

// Command codes
`define CMD_OPTION 8'h12
`define CMD_AMPS 8'h14
`define CMD_VOLTS 8'h15

// Option word bit positions
`define OPT_INHIBIT 0
`define OPT_TRIP 1
`define OPT_BOOST_ACT 2
`define OPT_BOOST_EN 3
`define OPT_ADAPTER 4
`define OPT_MON_SEL 5
`define OPT_LEARN 6
`define OPT_THR_LO 11
`define OPT_THR_HI 12

// Option word reset values
`define RST_INHIBIT 1'h0
`define RST_TRIP 1'h1
`define RST_BOOST_EN 1'h0
`define RST_MON_SEL 1'h0
`define RST_LEARN 1'h0
`define RST_THR 2'h3

// Charge current word: field 12:6, legal 128 mA to 8128 mA
`define AMPS_LSB 6
`define AMPS_MSB 12
`define AMPS_MIN 16'h0080
`define AMPS_MAX 16'h1FC0

// Charge voltage word: field 14:4, legal 1024 mV to 19200 mV
`define VOLTS_LSB 4
`define VOLTS_MSB 14
`define VOLTS_MIN 16'h0400
`define VOLTS_MAX 16'h4B00

// Power-on values of both setting words
`define RST_AMPS 7'h00
`define RST_VOLTS 11'h000

`endif

// ==== charger_pkg.sv ====
// Types shared by the setting register block
package charger_pkg;

    // Serial transfer phase
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_WLO,
        ST_WHI,
        ST_RLO,
        ST_RHI,
        ST_SKIP
    } link_state_t;

    // Comparator and status levels from the analog side
    typedef struct packed {
        logic adapter_present;
        logic boost_active;
        logic battery_depleted;
        logic cap_released;
        logic [6:0] cap_code;
    } analog_status_t;

    // Power path switch commands
    typedef struct packed {
        logic adapter_switch;
        logic battery_switch;
    } switch_cmd_t;

endpackage

// ==== charger_setting_registers.sv ====
// Setting registers of a battery charge controller behind a serial management link
//
// What this block does
// - Writing option bit 6 high starts calibration: adapter switch off, battery switch on.
// - Battery reaching depletion threshold with a nonzero voltage word ends calibration, restores switches, clears bit 6.
// - Writing bit 6 low aborts calibration; bit resets to zero.
// - Option bit 5 picks monitor source: 0 adapter amplifier, 1 charge amplifier.
// - Read-only bit 4 shows adapter sense above threshold; zero after reset.
// - Option bit 3 enables battery-assisted boost; reset value zero.
// - Read-only bit 2 shows converter in boost mode; zero after reset.
// - Option bit 1 enables adapter overcurrent trip; reset value one.
// - Option bit 0 inhibits charging when one; reset value zero.
// - Command 0x14 writes charge current, bits 12:6 weighted 64 mA upward.
// - Charge current write outside 128 mA to 8128 mA clears word, stops charging.
// - Charge current word is zero after reset.
// - Effective current limit is lower of word and cap pin; released cap ignored.
// - Command 0x15 writes charge voltage, bits 11:4 weighted 16 mV upward.
// - Voltage bits 12 to 14 add 4096, 8192, 16384 mV; bit 15 unused.
// - Charge voltage write outside 1024 mV to 19200 mV clears word, stops charging.
// - Charge voltage word is zero after reset.
// - Command 0x12 reads and writes the option word as 16 bits.
// - During calibration with a nonzero voltage word, depletion hands system power back to the adapter.
`include "charger_params.svh"

module charger_setting_registers #(
    parameter logic [6:0] SLAVE_ADDR = 7'h09
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Serial management link, open drain data
    input wire logic link_clk,
    input wire logic link_data_in,
    output logic link_data_out,
    output logic link_data_oe,
    // Analog status levels
    input charger_pkg::analog_status_t status_in,
    // Power path and converter controls
    output charger_pkg::switch_cmd_t switches,
    output logic current_monitor_output,
    output logic boost_enable,
    output logic adapter_overcurrent_trip,
    output logic charge_enable,
    output logic [1:0] depletion_threshold,
    output logic [6:0] charge_amps_field,
    output logic [10:0] charge_volts_field,
    output logic [6:0] effective_amps_limit
);

    // Two-stage synchronisers for every outside level
    logic [12:0] sync_a;
    logic [12:0] sync_b;
    logic scl_prev;
    logic sda_prev;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync_a <= 13'h0003;
            sync_b <= 13'h0003;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            sync_a <= {status_in, link_clk, link_data_in};
            sync_b <= sync_a;
            scl_prev <= sync_b[1];
            sda_prev <= sync_b[0];
        end
    end

    charger_pkg::analog_status_t status;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    assign status = charger_pkg::analog_status_t'(sync_b[12:2]);
    assign scl = sync_b[1];
    assign sda = sync_b[0];
    assign scl_rise = scl & ~scl_prev;
    assign scl_fall = ~scl & scl_prev;
    // Data edges only count as framing while the clock is high
    assign start_seen = scl & scl_prev & sda_prev & ~sda;
    assign stop_seen = scl & scl_prev & ~sda_prev & sda;

    // Register state
    logic learn;
    logic mon_sel;
    logic boost_en;
    logic trip_en;
    logic inhibit;
    logic [1:0] threshold;
    logic [6:0] amps;
    logic [10:0] volts;

    // Link transfer state
    charger_pkg::link_state_t st;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] cmd;
    logic [7:0] wlo;
    logic [15:0] tx_word;
    logic wr_stb;
    logic [15:0] wr_data;

    // Acknowledge slot of a byte and the clock fall that ends it
    logic ack_slot;
    logic ack_end;
    assign ack_slot = scl_fall && cnt == 4'h8;
    assign ack_end = scl_fall && cnt == 4'h9;

    // Read bits leave the top of the shift word first
    logic [3:0] tx_index;
    logic tx_bit;
    assign tx_index = 4'hF - cnt;
    assign tx_bit = tx_word[tx_index];

    // Option word as seen on a read
    logic [15:0] option_rd;
    always_comb begin
        option_rd = 16'h0000;
        option_rd[`OPT_THR_HI:`OPT_THR_LO] = threshold;
        option_rd[`OPT_LEARN] = learn;
        option_rd[`OPT_MON_SEL] = mon_sel;
        option_rd[`OPT_ADAPTER] = status.adapter_present;
        option_rd[`OPT_BOOST_EN] = boost_en;
        option_rd[`OPT_BOOST_ACT] = status.boost_active;
        option_rd[`OPT_TRIP] = trip_en;
        option_rd[`OPT_INHIBIT] = inhibit;
    end

    // Read word selected by the last command code; unknown codes read zero
    logic [15:0] rd_word;
    always_comb begin
        rd_word = 16'h0000;
        if (cmd == `CMD_OPTION) begin
            rd_word = option_rd;
        end else if (cmd == `CMD_AMPS) begin
            rd_word[`AMPS_MSB:`AMPS_LSB] = amps;
        end else if (cmd == `CMD_VOLTS) begin
            rd_word[`VOLTS_MSB:`VOLTS_LSB] = volts;
        end
    end

    // Serial slave: bits in on clock rise, data and acknowledge driven on clock fall
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st <= charger_pkg::ST_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            cmd <= 8'h00;
            wlo <= 8'h00;
            tx_word <= 16'h0000;
            link_data_oe <= 1'b0;
            wr_stb <= 1'b0;
            wr_data <= 16'h0000;
        end else begin
            wr_stb <= 1'b0;
            if (start_seen) begin
                // Repeated start keeps the command code for a read
                st <= charger_pkg::ST_ADDR;
                cnt <= 4'h0;
                link_data_oe <= 1'b0;
            end else if (stop_seen) begin
                st <= charger_pkg::ST_IDLE;
                link_data_oe <= 1'b0;
            end else if (st == charger_pkg::ST_RLO || st == charger_pkg::ST_RHI) begin
                if (scl_fall && cnt < 4'h8) begin
                    link_data_oe <= ~tx_bit;
                    cnt <= cnt + 4'h1;
                end else if (ack_slot) begin
                    link_data_oe <= 1'b0; // Host drives its acknowledge
                    cnt <= 4'h9;
                end else if (scl_rise && cnt == 4'h9) begin
                    cnt <= 4'h0;
                    if (!sda && st == charger_pkg::ST_RLO) begin
                        st <= charger_pkg::ST_RHI;
                        tx_word <= {tx_word[7:0], 8'h00};
                    end else begin
                        st <= charger_pkg::ST_SKIP;
                    end
                end
            end else if (st != charger_pkg::ST_IDLE && st != charger_pkg::ST_SKIP) begin
                if (scl_rise && cnt < 4'h8) begin
                    shreg <= {shreg[6:0], sda};
                    cnt <= cnt + 4'h1;
                end else if (ack_slot) begin
                    // Acknowledge only our own address; data bytes always
                    if (st == charger_pkg::ST_ADDR && shreg[7:1] != SLAVE_ADDR) begin
                        st <= charger_pkg::ST_SKIP;
                    end else begin
                        link_data_oe <= 1'b1;
                        cnt <= 4'h9;
                    end
                end else if (ack_end) begin
                    link_data_oe <= 1'b0;
                    cnt <= 4'h0;
                    unique case (st)
                        charger_pkg::ST_ADDR: begin
                            if (shreg[0]) begin
                                // First read bit goes out on this same fall
                                st <= charger_pkg::ST_RLO;
                                tx_word <= {rd_word[7:0], rd_word[15:8]};
                                link_data_oe <= ~rd_word[7];
                                cnt <= 4'h1;
                            end else begin
                                st <= charger_pkg::ST_CMD;
                            end
                        end
                        charger_pkg::ST_CMD: begin
                            cmd <= shreg;
                            st <= charger_pkg::ST_WLO;
                        end
                        charger_pkg::ST_WLO: begin
                            wlo <= shreg;
                            st <= charger_pkg::ST_WHI;
                        end
                        charger_pkg::ST_WHI: begin
                            // Low byte first, then high byte, forms the word
                            wr_data <= {shreg, wlo};
                            wr_stb <= 1'b1;
                            st <= charger_pkg::ST_SKIP;
                        end
                    endcase
                end
            end
        end
    end

    assign link_data_out = 1'b0;

    logic wr_option;
    logic wr_amps;
    logic wr_volts;
    assign wr_option = wr_stb && cmd == `CMD_OPTION;
    assign wr_amps = wr_stb && cmd == `CMD_AMPS;
    assign wr_volts = wr_stb && cmd == `CMD_VOLTS;

    // Range checks see the whole word, unused bits included
    logic amps_ok;
    logic volts_ok;
    assign amps_ok = wr_data >= `AMPS_MIN && wr_data <= `AMPS_MAX;
    assign volts_ok = wr_data >= `VOLTS_MIN && wr_data <= `VOLTS_MAX;

    // Host-written option bits; read-only positions ignore writes
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mon_sel <= `RST_MON_SEL;
            boost_en <= `RST_BOOST_EN;
            trip_en <= `RST_TRIP;
            inhibit <= `RST_INHIBIT;
            threshold <= `RST_THR;
        end else if (wr_option) begin
            mon_sel <= wr_data[`OPT_MON_SEL];
            boost_en <= wr_data[`OPT_BOOST_EN];
            trip_en <= wr_data[`OPT_TRIP];
            inhibit <= wr_data[`OPT_INHIBIT];
            threshold <= wr_data[`OPT_THR_HI:`OPT_THR_LO];
        end
    end

    // Calibration flag; a host write in the depletion cycle wins
    logic depleted;
    assign depleted = status.battery_depleted && volts != `RST_VOLTS;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            learn <= `RST_LEARN;
        end else if (wr_option) begin
            learn <= wr_data[`OPT_LEARN];
        end else if (learn && depleted) begin
            learn <= 1'b0;
        end
    end

    // Power path follows the calibration flag one cycle later
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            switches.adapter_switch <= 1'b1;
            switches.battery_switch <= 1'b0;
        end else begin
            switches.adapter_switch <= ~learn;
            switches.battery_switch <= learn;
        end
    end

    // Charge current word; out of range clears it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            amps <= `RST_AMPS;
        end else if (wr_amps) begin
            if (!amps_ok) begin
                amps <= `RST_AMPS;
            end else begin
                amps <= wr_data[`AMPS_MSB:`AMPS_LSB];
            end
        end
    end

    // Charge voltage word; out of range clears it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            volts <= `RST_VOLTS;
        end else if (wr_volts) begin
            if (!volts_ok) begin
                volts <= `RST_VOLTS;
            end else begin
                volts <= wr_data[`VOLTS_MSB:`VOLTS_LSB];
            end
        end
    end

    // The cap pin limits only while it is not released
    logic cap_wins;
    assign cap_wins = !status.cap_released && status.cap_code <= amps;

    // Outputs to the analog side, all registered
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            current_monitor_output <= `RST_MON_SEL;
            boost_enable <= `RST_BOOST_EN;
            adapter_overcurrent_trip <= `RST_TRIP;
            charge_enable <= 1'b0;
            depletion_threshold <= `RST_THR;
            charge_amps_field <= `RST_AMPS;
            charge_volts_field <= `RST_VOLTS;
            effective_amps_limit <= `RST_AMPS;
        end else begin
            current_monitor_output <= mon_sel;
            boost_enable <= boost_en;
            adapter_overcurrent_trip <= trip_en;
            // A zero word in either setting stops charging
            charge_enable <= ~inhibit && amps != `RST_AMPS && volts != `RST_VOLTS;
            depletion_threshold <= threshold;
            charge_amps_field <= amps;
            charge_volts_field <= volts;
            if (cap_wins) begin
                effective_amps_limit <= status.cap_code;
            end else begin
                effective_amps_limit <= amps;
            end
        end
    end

endmodule

// ==== charger_setting_registers_checker.sv ====
// Port-level checks for the charger setting registers
module charger_setting_registers_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Link clock and analog levels
    input wire logic link_clk,
    input charger_pkg::analog_status_t status_in,
    // Watched outputs
    input charger_pkg::switch_cmd_t switches,
    input wire logic charge_enable,
    input wire logic [1:0] depletion_threshold,
    input wire logic [6:0] charge_amps_field,
    input wire logic [10:0] charge_volts_field,
    input wire logic [6:0] effective_amps_limit
);
    timeunit 1ns;
    timeprecision 1ns;
    // Single domain, so one clock and one disable
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    reset_vals_a: assert property (
        $rose(rst_n) |-> switches == 2'b10 && !charge_enable && depletion_threshold == 2'b11
        && charge_amps_field == 7'h00 && charge_volts_field == 11'h000)
        else $error("Reset values wrong");
    switch_excl_a: assert property (
        switches.adapter_switch != switches.battery_switch)
        else $error("Switches not complementary");
    switch_idle_a: assert property (
        (link_clk && !status_in.battery_depleted)[*8] |-> $stable(switches))
        else $error("Switches moved with link idle");
    calib_end_a: assert property (
        switches.battery_switch && status_in.battery_depleted && charge_volts_field != 11'h000
        |-> ##[1:8] switches.adapter_switch)
        else $error("Calibration did not end");
    charge_gate_a: assert property (
        charge_enable |-> charge_amps_field != 7'h00 && charge_volts_field != 11'h000)
        else $error("Charging with a zero word");
    amps_range_a: assert property (
        charge_amps_field == 7'h00 || charge_amps_field >= 7'h02)
        else $error("Current word below range");
    volts_range_a: assert property (
        charge_volts_field == 11'h000
        || (charge_volts_field >= 11'h040 && charge_volts_field <= 11'h4B0))
        else $error("Voltage word out of range");
    limit_min_a: assert property (
        effective_amps_limit <= charge_amps_field)
        else $error("Limit above current word");
    cap_limit_a: assert property (
        ($stable(status_in) && !status_in.cap_released)[*6]
        |-> effective_amps_limit <= status_in.cap_code)
        else $error("Limit above cap pin");
    fields_idle_a: assert property (
        link_clk[*8] |-> $stable(charge_amps_field) && $stable(charge_volts_field)
        && $stable(depletion_threshold))
        else $error("Setting changed with link idle");

    // Main scenarios reached
    calib_c: cover property (switches.battery_switch);
    charge_c: cover property (charge_enable);
    capped_c: cover property (effective_amps_limit < charge_amps_field);
endmodule

bind charger_setting_registers charger_setting_registers_checker
    charger_setting_registers_checker_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .link_clk(link_clk), .status_in(status_in),
    .switches(switches), .charge_enable(charge_enable),
    .depletion_threshold(depletion_threshold), .charge_amps_field(charge_amps_field),
    .charge_volts_field(charge_volts_field), .effective_amps_limit(effective_amps_limit));

// ==== link_host.sv ====
// Host model on the serial management link, open-drain data with pull-up
module link_host (
    // Clock
    input wire logic clk_sys,
    // Link wires
    output logic link_clk,
    output wire link_data_in,
    input wire logic link_data_oe,
    input wire logic link_data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic host_low = 1'b0;
    initial link_clk = 1'b1;

    // Pull-up wins unless a party pulls low
    assign link_data_in = ~host_low & (link_data_oe ? link_data_out : 1'b1);

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // One link clock: data moves only while the clock is low
    task automatic bit_cycle(input logic pull, output logic level);
        link_clk = 1'b0;
        tick(1);
        host_low = pull;
        tick(3);
        link_clk = 1'b1;
        tick(4);
        level = link_data_in;
    endtask

    task automatic send_byte(input logic [7:0] b, inout logic ok);
        logic lvl;
        for (int i = 7; i >= 0; i--) bit_cycle(~b[i], lvl);
        bit_cycle(1'b0, lvl);
        ok = ok & ~lvl;
    endtask

    task automatic recv_byte(output logic [7:0] b, input logic last);
        logic lvl;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b0, lvl);
            b[i] = lvl;
        end
        bit_cycle(~last, lvl);
    endtask

    // Stop: data rises while the clock is high, then the clock stands still
    task automatic stop_frame();
        logic lvl;
        bit_cycle(1'b1, lvl);
        host_low = 1'b0;
        tick(4);
    endtask

    // Word write by command code, low byte first
    task automatic write_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
        output logic ok);
        ok = 1'b1;
        host_low = 1'b1;
        tick(4);
        send_byte({a, 1'b0}, ok);
        send_byte(c, ok);
        send_byte(d[7:0], ok);
        send_byte(d[15:8], ok);
        stop_frame();
    endtask

    // Word read: command, repeated start, low byte acked, high byte not
    task automatic read_word(input logic [6:0] a, input logic [7:0] c, output logic [15:0] d,
        output logic ok);
        logic lvl;
        ok = 1'b1;
        host_low = 1'b1;
        tick(4);
        send_byte({a, 1'b0}, ok);
        send_byte(c, ok);
        bit_cycle(1'b0, lvl);
        host_low = 1'b1;
        tick(4);
        send_byte({a, 1'b1}, ok);
        recv_byte(d[7:0], 1'b0);
        recv_byte(d[15:8], 1'b1);
        stop_frame();
    endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the charger setting registers
`include "charger_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] ADDR = 7'h09;
    localparam logic [15:0] V_IN [5] = '{16'h0400, 16'h03F0, 16'h4B00, 16'h4B10, 16'h3001};
    localparam logic [10:0] V_EXP [5] = '{11'h040, 11'h000, 11'h4B0, 11'h000, 11'h300};
    localparam logic [15:0] A_IN [5] = '{16'h0080, 16'h0040, 16'h1FC0, 16'h2000, 16'h0FFF};
    localparam logic [6:0] A_EXP [5] = '{7'h02, 7'h00, 7'h7F, 7'h00, 7'h3F};
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic link_clk;
    wire link_data_in;
    logic link_data_oe;
    logic link_data_out;
    logic ok;
    logic [15:0] rd;
    charger_pkg::analog_status_t status_in = '0;
    charger_pkg::switch_cmd_t switches;
    logic mon, boost, trip, chg_en;
    logic [1:0] thr;
    logic [6:0] amps, eff;
    logic [10:0] volts;
    int fails = 0;
    int total_checks = 0;

    // Free-running system clock
    always #50 clk_sys = ~clk_sys;

    charger_setting_registers #(.SLAVE_ADDR(ADDR)) charger_setting_registers_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .link_clk(link_clk),
        .link_data_in(link_data_in), .link_data_out(link_data_out), .link_data_oe(link_data_oe),
        .status_in(status_in), .switches(switches), .current_monitor_output(mon),
        .boost_enable(boost), .adapter_overcurrent_trip(trip), .charge_enable(chg_en),
        .depletion_threshold(thr), .charge_amps_field(amps),
        .charge_volts_field(volts), .effective_amps_limit(eff));

    link_host link_host_inst (.clk_sys(clk_sys), .link_clk(link_clk),
        .link_data_in(link_data_in), .link_data_oe(link_data_oe), .link_data_out(link_data_out));

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic print_verdict();
        if (fails == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
        link_host_inst.write_word(ADDR, cmd, d, ok);
        chk("write ack", 16'h0001, {15'h0, ok});
    endtask

    task automatic rdchk(input logic [7:0] cmd, input logic [15:0] exp);
        link_host_inst.read_word(ADDR, cmd, rd, ok);
        chk("read ack", 16'h0001, {15'h0, ok});
        chk("read data", exp, rd);
    endtask

    // Power-on values at the pins and over the link
    task automatic test_reset();
        chk("switches", 16'h0002, {14'h0, switches});
        chk("monitor", 16'h0000, {15'h0, mon});
        chk("boost", 16'h0000, {15'h0, boost});
        chk("trip", 16'h0001, {15'h0, trip});
        chk("enable", 16'h0000, {15'h0, chg_en});
        rdchk(`CMD_OPTION, 16'h1802);
        rdchk(`CMD_AMPS, 16'h0000);
        rdchk(`CMD_VOLTS, 16'h0000);
    endtask

    // Status bits follow the inputs, never the written value
    task automatic test_option();
        status_in.adapter_present = 1'b1;
        wr(`CMD_OPTION, 16'h003F);
        chk("monitor", 16'h0001, {15'h0, mon});
        chk("boost", 16'h0001, {15'h0, boost});
        chk("trip", 16'h0001, {15'h0, trip});
        chk("threshold", 16'h0000, {14'h0, thr});
        rdchk(`CMD_OPTION, 16'h003B);
        status_in.adapter_present = 1'b0;
        status_in.boost_active = 1'b1;
        wr(`CMD_OPTION, 16'h1800);
        chk("trip", 16'h0000, {15'h0, trip});
        chk("monitor", 16'h0000, {15'h0, mon});
        rdchk(`CMD_OPTION, 16'h1804);
        status_in.boost_active = 1'b0;
    endtask

    // Both range edges; unused bits dropped on read
    task automatic test_volts();
        for (int i = 0; i < 5; i++) begin
            wr(`CMD_VOLTS, V_IN[i]);
            chk("volts", {5'h0, V_EXP[i]}, {5'h0, volts});
            rdchk(`CMD_VOLTS, {1'b0, V_EXP[i], 4'h0});
        end
    endtask

    task automatic test_amps();
        for (int i = 0; i < 5; i++) begin
            wr(`CMD_AMPS, A_IN[i]);
            chk("amps", {9'h0, A_EXP[i]}, {9'h0, amps});
            chk("enable", {15'h0, A_EXP[i] != 7'h00}, {15'h0, chg_en});
            rdchk(`CMD_AMPS, {3'h0, A_EXP[i], 6'h0});
        end
        wr(`CMD_OPTION, 16'h1801);
        chk("enable", 16'h0000, {15'h0, chg_en});
        wr(`CMD_OPTION, 16'h1800);
        chk("enable", 16'h0001, {15'h0, chg_en});
    endtask

    // Cap below, released, and above a current word of 0x3F
    task automatic test_cap();
        status_in.cap_code = 7'h10;
        tick(6);
        chk("limit", 16'h0010, {9'h0, eff});
        status_in.cap_released = 1'b1;
        tick(6);
        chk("limit", 16'h003F, {9'h0, eff});
        status_in.cap_released = 1'b0;
        status_in.cap_code = 7'h7F;
        tick(6);
        chk("limit", 16'h003F, {9'h0, eff});
    endtask

    // Discharge ended by depletion, then started again and aborted
    task automatic test_calib();
        wr(`CMD_OPTION, 16'h0040);
        chk("switches", 16'h0001, {14'h0, switches});
        rdchk(`CMD_OPTION, 16'h0040);
        status_in.battery_depleted = 1'b1;
        for (int n = 0; n < 20 && switches !== 2'b10; n++) tick(1);
        chk("switches", 16'h0002, {14'h0, switches});
        if (switches !== 2'b10) return;
        rdchk(`CMD_OPTION, 16'h0000);
        status_in.battery_depleted = 1'b0;
        wr(`CMD_OPTION, 16'h0040);
        chk("switches", 16'h0001, {14'h0, switches});
        wr(`CMD_OPTION, 16'h0000);
        chk("switches", 16'h0002, {14'h0, switches});
    endtask

    // A frame for another address changes nothing
    task automatic test_address();
        link_host_inst.write_word(7'h0A, `CMD_AMPS, 16'h0080, ok);
        chk("foreign ack", 16'h0000, {15'h0, ok});
        chk("amps", 16'h003F, {9'h0, amps});
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        tick(6);
        test_reset();
        test_option();
        test_volts();
        test_amps();
        test_cap();
        test_calib();
        test_address();
        print_verdict();
    end
endmodule
